/* File: dv/cdfr_host.sv */
// avalon-mm master model of the system controller
`timescale 1ns/1ps
`default_nettype none
module cdfr_host (
   input  wire logic        clk,      // clock
   input  wire logic [31:0] rdata,    // read data
   input  wire logic        waitreq,  // stall
   output var  logic [3:0]  address,  // byte address
   output var  logic        read,     // read request
   output var  logic        write,    // write request
   output var  logic [31:0] wdata,    // write data
   output var  logic        page      // irq enable page
);
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      wdata = 32'h0;
      page = 1'b0;
   end
   task automatic access(input logic wr, input logic pg, input logic [3:0] a,
                         input logic [31:0] d, output logic [31:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = 32'h0;
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      page <= pg;
      wdata <= d;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge clk);
         if (!waitreq) begin
            ok = 1'b1;
            q = rdata;
         end
      end
      // read and write drop to 0, address and wdata are inverted; page keeps the last value
      read <= 1'b0;
      write <= 1'b0;
      address <= ~a;
      wdata <= ~d;
   endtask : access
endmodule : cdfr_host
`default_nettype wire

/* File: dv/cdfr_props.sv */
// port checker of the caption fifo readout
`timescale 1ns/1ps
`default_nettype none
module cdfr_props (
   input wire logic        ref_clk,            // clock
   input wire logic        resetn,             // async reset, active low
   input wire logic        avs_read,           // read request
   input wire logic        avs_write,          // write request
   input wire logic [31:0] avs_readdata,       // read data
   input wire logic        avs_waitrequest,    // stall
   input wire logic        dec_valid,          // decoder byte strobe
   input wire logic        caption_ready_irq,  // level interrupt
   input wire logic        fifo_overflow       // overflow flag copy
);
   wire ack = !avs_waitrequest;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_ack_next_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> ack)
      else $error("access not answered after one cycle");
   a_ack_one_cycle: assert property (ack |=> !ack)
      else $error("answer held longer than one cycle");
   a_idle_data_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("read data not zero outside an answer");
   a_upper_bits_zero: assert property (ack |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_ovf_rise_drop: assert property ($rose(fifo_overflow) |->
      $past(dec_valid, 2) || $past(dec_valid, 3))
      else $error("overflow set without an arriving byte");
   a_ovf_fall_read: assert property ($fell(fifo_overflow) |->
      $past(ack, 2) || $past(ack, 3) || $past(ack, 4))
      else $error("overflow cleared without a host access");
   a_irq_rise_cause: assert property ($rose(caption_ready_irq) |-> $past(dec_valid, 2) ||
      $past(dec_valid, 3) || $past(dec_valid, 4) || $past(ack, 1) || $past(ack, 2))
      else $error("interrupt raised without an event");
   a_irq_fall_cause: assert property ($fell(caption_ready_irq) |->
      $past(ack, 1) || $past(ack, 2) || $past(ack, 3))
      else $error("interrupt dropped without a host write");
endmodule : cdfr_props
bind cdfr_top cdfr_props chk_u (
   .ref_clk(ref_clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dec_valid(dec_valid),
   .caption_ready_irq(caption_ready_irq), .fifo_overflow(fifo_overflow));
`default_nettype wire

/* File: dv/tb_caption_data_fifo_readout.sv */
// self-checking bench of the caption fifo readout
`timescale 1ns/1ps
`default_nettype none
module tb_caption_data_fifo_readout;
   logic        ref_clk;
   logic        resetn;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [31:0] wdata;
   logic        page;
   logic [3:0]  be;
   logic [31:0] rdata;
   logic        waitreq;
   logic        dec_valid;
   logic [7:0]  dec_byte;
   logic        dec_kind;
   logic        dec_half;
   logic        irq;
   logic        ovf;
   logic [31:0] q;
   logic        ok;
   int          miscompares;
   int          n_tests;
   int          j;

   cdfr_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .avs_address(address),
      .avs_read(read), .avs_write(write), .avs_writedata(wdata), .avs_byteenable(be),
      .avs_irq_en_sel(page), .avs_readdata(rdata), .avs_waitrequest(waitreq),
      .dec_valid(dec_valid), .dec_byte(dec_byte), .dec_kind(dec_kind),
      .dec_half(dec_half), .caption_ready_irq(irq), .fifo_overflow(ovf));
   cdfr_host host_u (.clk(ref_clk), .rdata(rdata), .waitreq(waitreq), .address(address),
      .read(read), .write(write), .wdata(wdata), .page(page));

   task automatic final_report();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic w, input logic pg, input logic [3:0] a, input logic [31:0] d);
      host_u.access(w, pg, a, d, q, ok);
      if (!ok) begin
         chk("bus answer", 32'h0, 32'h1);
         final_report();
      end
   endtask : bus
   task automatic rc(input string name, input logic pg, input logic [3:0] a,
                     input logic [31:0] exp);
      bus(1'b0, pg, a, 32'h0);
      chk(name, q, exp);
   endtask : rc
   task automatic push(input logic [7:0] b, input logic k, input logic h);
      @(posedge ref_clk);
      dec_valid <= 1'b1;
      dec_byte <= b;
      dec_kind <= k;
      dec_half <= h;
      @(posedge ref_clk);
      dec_valid <= 1'b0;
      dec_byte <= ~b;
   endtask : push
   task automatic fill();
      int k;
      for (k = 0; k < 16; k++) begin
         push(8'(k + 16), k[1], k[0]);
      end
      push(8'hEE, 1'b0, 1'b0);
   endtask : fill

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial begin
      miscompares = 0;
      n_tests = 0;
      dec_valid = 1'b0;
      dec_byte = 8'h0;
      dec_kind = 1'b0;
      dec_half = 1'b0;
      be = 4'hF;
      resetn = 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rc("status", 1'b0, 4'h4, 32'h0);
      push(8'h55, 1'b0, 1'b0);
      rc("byte disabled", 1'b0, 4'h0, 32'h0);
      rc("unmapped", 1'b0, 4'h2, 32'h0);
      $display("test reset done");
      bus(1'b1, 1'b0, 4'h4, 32'h30);
      bus(1'b1, 1'b1, 4'h4, 32'h1);
      rc("irq enable", 1'b1, 4'h4, 32'h1);
      push(8'hA1, 1'b1, 1'b0);
      rc("status one", 1'b0, 4'h4, 32'h35);
      rc("irq status one", 1'b0, 4'h8, 32'h4);
      rc("byte one", 1'b0, 4'h0, 32'hA1);
      rc("status popped", 1'b0, 4'h4, 32'h30);
      bus(1'b1, 1'b0, 4'hC, 32'h7);
      $display("test single entry done");
      fill();
      rc("status full", 1'b0, 4'h4, 32'h73);
      rc("irq status full", 1'b0, 4'h8, 32'h7);
      chk("irq pin", {31'h0, irq}, 32'h1);
      chk("overflow pin", {31'h0, ovf}, 32'h1);
      for (j = 0; j < 16; j++) begin
         rc("status entry", 1'b0, 4'h4, 32'h31 | {25'h0, (j <= 8), 2'h0, j[0], j[1], (j == 0), 1'b0});
         rc("fifo byte", 1'b0, 4'h0, 32'(j) + 32'h10);
      end
      rc("status drained", 1'b0, 4'h4, 32'h30);
      chk("overflow pin", {31'h0, ovf}, 32'h0);
      bus(1'b1, 1'b0, 4'hC, 32'h7);
      rc("irq cleared", 1'b0, 4'h8, 32'h0);
      chk("irq pin", {31'h0, irq}, 32'h0);
      $display("test overflow done");
      bus(1'b1, 1'b1, 4'h4, 32'h0);
      fill();
      chk("irq masked", {31'h0, irq}, 32'h0);
      fork
         rc("byte coincide", 1'b0, 4'h0, 32'h10);
         begin
            repeat (2) @(posedge ref_clk);
            dec_valid <= 1'b1;
            @(posedge ref_clk);
            dec_valid <= 1'b0;
         end
      join
      rc("status coincide", 1'b0, 4'h4, 32'h7B);
      rc("byte extra", 1'b0, 4'h0, 32'h11);
      rc("status extra", 1'b0, 4'h4, 32'h75);
      $display("test coincide done");
      be <= 4'h0;
      bus(1'b1, 1'b0, 4'h4, 32'h0);
      be <= 4'hF;
      rc("status lane off", 1'b0, 4'h4, 32'h75);
      bus(1'b1, 1'b0, 4'h4, 32'h0);
      rc("status flushed", 1'b0, 4'h4, 32'h0);
      rc("byte flushed", 1'b0, 4'h0, 32'h0);
      bus(1'b1, 1'b0, 4'h4, 32'h10);
      push(8'h66, 1'b1, 1'b1);
      rc("kind disabled", 1'b0, 4'h4, 32'h10);
      push(8'h67, 1'b0, 1'b1);
      rc("kind enabled", 1'b0, 4'h4, 32'h19);
      rc("byte enabled", 1'b0, 4'h0, 32'h67);
      fork
         rc("byte race", 1'b0, 4'h0, 32'h0);
         begin
            @(posedge ref_clk);
            dec_valid <= 1'b1;
            @(posedge ref_clk);
            dec_valid <= 1'b0;
         end
      join
      rc("status race", 1'b0, 4'h4, 32'h19);
      rc("byte race kept", 1'b0, 4'h0, 32'h98);
      $display("test flush done");
      final_report();
   end
endmodule : tb_caption_data_fifo_readout
`default_nettype wire

/* File: logic/cdfr_fifo.sv */
// show-ahead fifo with read priority and overflow tracking
`timescale 1ns/1ps
`default_nettype none
module cdfr_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,        // clock
   input  wire logic             resetn,     // async reset, active low
   input  wire logic             flush,      // discard all entries
   input  wire logic             push,       // write request
   input  wire logic [WIDTH-1:0] push_data,  // write entry
   input  wire logic             pop,        // read request
   output logic      [WIDTH-1:0] head_data,  // oldest entry
   output logic                  empty,      // no entry held
   output logic                  full,       // no room
   output logic                  half_full,  // at least depth/2 held
   output logic                  overflow    // entry lost while full
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("cdfr_fifo: depth must be a power of two of at least 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW:0]      count_reg;
   logic             ovf_reg;
   logic             do_pop;
   logic             do_push;

   assign empty     = (count_reg == '0);
   assign full      = (count_reg == (AW+1)'(DEPTH));
   assign half_full = (count_reg >= (AW+1)'(DEPTH / 2));
   assign head_data = mem[rd_ptr_reg];
   assign overflow  = ovf_reg;

   assign do_pop  = pop & ~empty;
   assign do_push = push & ~full;

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= push_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         count_reg  <= '0;
      end else if (flush) begin
         rd_ptr_reg <= '0;
         wr_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (do_pop && !do_push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // a write lost in the same cycle as a read keeps the flag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ovf_reg <= 1'b0;
      end else if (flush) begin
         ovf_reg <= 1'b0;
      end else if (push && full) begin
         ovf_reg <= 1'b1;
      end else if (do_pop) begin
         ovf_reg <= 1'b0;
      end
   end

endmodule : cdfr_fifo
`default_nettype wire

/* File: logic/cdfr_map.svh */
// register offsets, field positions and reset values of the caption fifo readout
`ifndef CDFR_MAP_SVH
`define CDFR_MAP_SVH

`define CDFR_ADDR_W          4
`define CDFR_OFS_BYTE        4'h0
`define CDFR_OFS_STATUS      4'h4
`define CDFR_OFS_IRQ_STAT    4'h8
`define CDFR_OFS_IRQ_CLR     4'hC

// irq enable sits at the status offset of the second page
`define CDFR_OFS_IRQ_EN_IDX  4'h4

`define CDFR_ST_AVAIL        0
`define CDFR_ST_OVF          1
`define CDFR_ST_KIND         2
`define CDFR_ST_HALF         3
`define CDFR_ST_CAP_EN       4
`define CDFR_ST_EXT_EN       5
`define CDFR_ST_HALF_FULL    6
`define CDFR_ST_CTRL_RST     2'h0

`define CDFR_EV_HALF_FULL    0
`define CDFR_EV_OVF          1
`define CDFR_EV_ARRIVE       2
`define CDFR_EV_W            3
`define CDFR_EV_RST          3'h0

`define CDFR_DATA_W          8
`define CDFR_DEPTH           16

`endif

/* File: logic/cdfr_pkg.sv */
// types of the caption fifo readout
`default_nettype none
package cdfr_pkg;

   typedef enum logic [1:0] {
      CDFR_BUS_IDLE = 2'b00,
      CDFR_BUS_ACK  = 2'b01
   } cdfr_bus_state_t;

   typedef enum logic [0:0] {
      CDFR_KIND_CAPTION = 1'b0,
      CDFR_KIND_EXTDATA = 1'b1
   } cdfr_kind_t;

endpackage : cdfr_pkg
`default_nettype wire

/* File: logic/cdfr_top.sv */
// caption and extended data byte fifo with avalon-mm register readout
`timescale 1ns/1ps
`default_nettype none
`include "cdfr_map.svh"

module cdfr_top #(
   parameter int DATA_W = `CDFR_DATA_W,
   parameter int DEPTH  = `CDFR_DEPTH
) (
   input  wire logic                   ref_clk,            // 125 MHz clock
   input  wire logic                   resetn,             // async reset, active low
   input  wire logic [`CDFR_ADDR_W-1:0] avs_address,       // byte address
   input  wire logic                   avs_read,           // read request
   input  wire logic                   avs_write,          // write request
   input  wire logic [31:0]            avs_writedata,      // write data
   input  wire logic [3:0]             avs_byteenable,     // byte lanes
   input  wire logic                   avs_irq_en_sel,     // selects irq enable page
   output logic      [31:0]            avs_readdata,       // read data
   output logic                        avs_waitrequest,    // stall
   input  wire logic                   dec_valid,          // decoder byte strobe
   input  wire logic [DATA_W-1:0]      dec_byte,           // decoded byte with parity
   input  wire logic                   dec_kind,           // 1 extended data, 0 caption
   input  wire logic                   dec_half,           // 1 high byte, 0 low byte
   output logic                        caption_ready_irq,  // level interrupt
   output logic                        fifo_overflow       // overflow flag copy
);
   localparam int EW = DATA_W + 2;

   initial begin
      if (DATA_W < 1 || DATA_W > 24) begin
         $error("cdfr_top: data width must be 1 to 24");
      end
   end

   cdfr_pkg::cdfr_bus_state_t bus_state_reg;
   logic                   waitreq_reg;
   logic [31:0]            rdata_reg;
   logic [1:0]             cap_en_reg;
   logic [`CDFR_EV_W-1:0]  ev_stat_reg;
   logic [`CDFR_EV_W-1:0]  ev_en_reg;
   logic [`CDFR_EV_W-1:0]  ev_set;
   logic                   irq_reg;
   logic                   ovf_out_reg;
   logic                   half_full_q_reg;
   logic                   empty_q_reg;
   logic                   pop_armed_reg;

   logic                   fifo_flush;
   logic                   fifo_push;
   logic                   fifo_pop;
   logic [EW-1:0]          push_entry;
   logic [EW-1:0]          head_entry;
   logic                   fifo_empty;
   logic                   fifo_full;
   logic                   fifo_half;
   logic                   fifo_ovf;
   logic                   rd_done;
   logic                   wr_done;
   logic                   kind_enabled;
   logic [31:0]            status_word;
   logic [31:0]            rdata_next;

   // ---------------- fifo ----------------
   assign fifo_flush = (cap_en_reg == 2'h0);
   assign kind_enabled = dec_kind ? cap_en_reg[1] : cap_en_reg[0];
   assign fifo_push  = dec_valid & kind_enabled & ~fifo_flush;
   assign push_entry = {dec_kind, dec_half, dec_byte};

   // one pop per accepted read of the byte offset while not empty, aligned to the edge the master samples
   assign rd_done  = (bus_state_reg == cdfr_pkg::CDFR_BUS_ACK) & avs_read;
   assign wr_done  = (bus_state_reg == cdfr_pkg::CDFR_BUS_ACK) & avs_write;
   assign fifo_pop = rd_done & pop_armed_reg;

   cdfr_fifo #(
      .WIDTH (EW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (ref_clk),
      .resetn    (resetn),
      .flush     (fifo_flush),
      .push      (fifo_push),
      .push_data (push_entry),
      .pop       (fifo_pop),
      .head_data (head_entry),
      .empty     (fifo_empty),
      .full      (fifo_full),
      .half_full (fifo_half),
      .overflow  (fifo_ovf)
   );

   // ---------------- status word ----------------
   always_comb begin
      status_word                     = 32'h0000_0000;
      status_word[`CDFR_ST_AVAIL]     = ~fifo_empty;
      status_word[`CDFR_ST_OVF]       = fifo_ovf;
      status_word[`CDFR_ST_KIND]      = fifo_empty ? 1'b0 : head_entry[EW-1];
      status_word[`CDFR_ST_HALF]      = fifo_empty ? 1'b0 : head_entry[EW-2];
      status_word[`CDFR_ST_CAP_EN]    = cap_en_reg[0];
      status_word[`CDFR_ST_EXT_EN]    = cap_en_reg[1];
      status_word[`CDFR_ST_HALF_FULL] = fifo_half;
   end

   // ---------------- bus slave ----------------
   // every access answers on the second edge: waitrequest low one cycle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bus_state_reg <= cdfr_pkg::CDFR_BUS_IDLE;
         waitreq_reg   <= 1'b1;
      end else begin
         case (bus_state_reg)
            cdfr_pkg::CDFR_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state_reg <= cdfr_pkg::CDFR_BUS_ACK;
                  waitreq_reg   <= 1'b0;
               end
            end
            cdfr_pkg::CDFR_BUS_ACK: begin
               bus_state_reg <= cdfr_pkg::CDFR_BUS_IDLE;
               waitreq_reg   <= 1'b1;
            end
            default: begin
               bus_state_reg <= cdfr_pkg::CDFR_BUS_IDLE;
               waitreq_reg   <= 1'b1;
            end
         endcase
      end
   end

   // read data captured from the live head, so a fresh byte is seen at once
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (avs_irq_en_sel) begin
         if (avs_address == `CDFR_OFS_IRQ_EN_IDX) begin
            rdata_next[`CDFR_EV_W-1:0] = ev_en_reg;
         end
      end else if (avs_address == `CDFR_OFS_BYTE) begin
         if (!fifo_empty) begin
            rdata_next[DATA_W-1:0] = head_entry[DATA_W-1:0];
         end
      end else if (avs_address == `CDFR_OFS_STATUS) begin
         rdata_next = status_word;
      end else if (avs_address == `CDFR_OFS_IRQ_STAT) begin
         rdata_next[`CDFR_EV_W-1:0] = ev_stat_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (bus_state_reg == cdfr_pkg::CDFR_BUS_IDLE && avs_read) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // a read taken while empty returns 0 and must not pop a byte landing meanwhile
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pop_armed_reg <= 1'b0;
      end else if (bus_state_reg == cdfr_pkg::CDFR_BUS_IDLE && avs_read) begin
         pop_armed_reg <= ~fifo_empty & ~avs_irq_en_sel
                          & (avs_address == `CDFR_OFS_BYTE);
      end else begin
         pop_armed_reg <= 1'b0;
      end
   end

   // control bits: capture enables
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cap_en_reg <= `CDFR_ST_CTRL_RST;
      end else if (wr_done && !avs_irq_en_sel && avs_address == `CDFR_OFS_STATUS
                   && avs_byteenable[0]) begin
         cap_en_reg <= {avs_writedata[`CDFR_ST_EXT_EN], avs_writedata[`CDFR_ST_CAP_EN]};
      end
   end

   // irq enable register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ev_en_reg <= `CDFR_EV_RST;
      end else if (wr_done && avs_irq_en_sel && avs_address == `CDFR_OFS_IRQ_EN_IDX
                   && avs_byteenable[0]) begin
         ev_en_reg <= avs_writedata[`CDFR_EV_W-1:0];
      end
   end

   // ---------------- events and interrupt ----------------
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         half_full_q_reg <= 1'b0;
         empty_q_reg     <= 1'b1;
      end else begin
         half_full_q_reg <= fifo_half;
         empty_q_reg     <= fifo_empty;
      end
   end

   always_comb begin
      ev_set                     = '0;
      ev_set[`CDFR_EV_HALF_FULL] = fifo_half & ~half_full_q_reg;
      ev_set[`CDFR_EV_OVF]       = fifo_push & fifo_full;
      ev_set[`CDFR_EV_ARRIVE]    = ~fifo_empty & empty_q_reg;
   end

   // sticky status, set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ev_stat_reg <= `CDFR_EV_RST;
      end else if (wr_done && !avs_irq_en_sel && avs_address == `CDFR_OFS_IRQ_CLR
                   && avs_byteenable[0]) begin
         ev_stat_reg <= (ev_stat_reg & ~avs_writedata[`CDFR_EV_W-1:0]) | ev_set;
      end else begin
         ev_stat_reg <= ev_stat_reg | ev_set;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_reg     <= 1'b0;
         ovf_out_reg <= 1'b0;
      end else begin
         irq_reg     <= |(ev_stat_reg & ev_en_reg);
         ovf_out_reg <= fifo_ovf;
      end
   end

   assign avs_readdata      = rdata_reg;
   assign avs_waitrequest   = waitreq_reg;
   assign caption_ready_irq = irq_reg;
   assign fifo_overflow     = ovf_out_reg;

endmodule : cdfr_top
`default_nettype wire
